// ### core/ifsc_params.svh
// constants of the serial configuration port and its register bank
// assumes inclusion by core files only; definitions only
`ifndef IFSC_PARAMS_SVH
`define IFSC_PARAMS_SVH

// frame layout
`define IFSC_ADDR_BITS      4
`define IFSC_DATA_BITS      8
`define IFSC_FRAME_BITS     12
`define IFSC_CNT_FULL       4'hC

// register addresses
`define IFSC_A_GAIN         4'h0
`define IFSC_A_TARGET       4'h1
`define IFSC_A_DELAY        4'h2
`define IFSC_A_STROBE       4'h3
`define IFSC_A_CTRL         4'h4
`define IFSC_A_LOOP         4'h5
`define IFSC_A_FINE_HI      4'h6
`define IFSC_A_FINE_LO      4'h7
`define IFSC_A_COARSE       4'h8
`define IFSC_A_SOFT_RST     4'hF

// reset values
`define IFSC_R_GAIN         8'h00
`define IFSC_R_TARGET       8'h20
`define IFSC_R_DELAY        8'h00
`define IFSC_R_STROBE       8'h10
`define IFSC_R_CTRL         8'h01
`define IFSC_R_LOOP         8'h0C
`define IFSC_R_FINE_HI      8'h00
`define IFSC_R_FINE_LO      8'h00
`define IFSC_R_COARSE       8'h00

// implemented bits; the rest are unused and dropped
`define IFSC_M_GAIN         8'hFF
`define IFSC_M_TARGET       8'h3F
`define IFSC_M_DELAY        8'hFF
`define IFSC_M_STROBE       8'h7F
`define IFSC_M_CTRL         8'h0F
`define IFSC_M_LOOP         8'h1F
`define IFSC_M_FINE_HI      8'hFF
`define IFSC_M_FINE_LO      8'h03
`define IFSC_M_COARSE       8'h0F

// field positions
`define IFSC_B_SOFT_RST     0
`define IFSC_B_BLK_DLY      5
`define IFSC_B_VID_DLY      2
`define IFSC_B_RSTREJ       6
`define IFSC_B_STR_TEST     5
`define IFSC_B_CLAMP_OPT    4
`define IFSC_B_BLK_POL      3
`define IFSC_B_VID_POL      2
`define IFSC_B_CLAMP_POL    1
`define IFSC_B_CAL_POL      0
`define IFSC_B_DLY_TEST     3
`define IFSC_B_ADC_TEST     2
`define IFSC_B_PWR_DOWN     1
`define IFSC_B_OUT_EN       0
`define IFSC_B_CAL_HOLD     4
`define IFSC_B_SPEED_UP     3
`define IFSC_B_NF_ON        2
`define IFSC_B_NF_NARROW    1
`define IFSC_B_MAN_DAC      0

`endif

// ### core/ifsc_pkg.sv
// types shared by the serial configuration port
// assumes the params header is on the include path
package ifsc_pkg;

    // register bank contents, one byte per defined address except the soft reset one
    typedef struct packed {
        logic [7:0] gain_code;
        logic [7:0] black_offset_target;
        logic [7:0] aperture_delays;
        logic [7:0] strobe_polarity_cfg;
        logic [7:0] power_output_ctrl;
        logic [7:0] offset_loop_cfg;
        logic [7:0] fine_offset_high;
        logic [7:0] fine_offset_low;
        logic [7:0] coarse_offset;
    } ifsc_regs_s;

    // state on the shift clock
    typedef struct packed {
        logic [11:0] shift_word;
        logic [3:0]  bit_cnt;
    } ifsc_link_s;

    // state on the system clock
    typedef struct packed {
        logic       load_s1;
        logic       load_s2;
        logic       load_s3;
        ifsc_regs_s regs;
        logic       chip_reset;
        logic       discard;
    } ifsc_core_s;

endpackage

// ### core/ifsc_serial_config.sv
// three-wire write-only configuration port and its register bank
// assumes sclk is the host's shift clock, idle while the strobe is high,
// and that serial_in and load change away from the rising sclk edge
`timescale 1ns/1ps

`include "ifsc_params.svh"

// Overview of operation
// RQ1: three input wires, write only, no readback
// RQ2: twelve-bit shift: four address, eight data
// RQ3: address then data, msb first
// RQ4: strobe low lets shifting happen
// RQ5: strobe rise commits byte to addressed register
// RQ6: no address check, nothing read back
// RQ7: undefined address discards data
// RQ8: host avoids traffic during active video
// RQ9: host clocks only while shifting
// RQ10: host soft-resets after power-up
// RQ11: gain code, reset minimum
// RQ12: target black offset, reset 20h
// RQ13: two aperture delays plus test bits
// RQ14: noise rejection, test bit, clamp option
// RQ15: four input polarity bits, reset low
// RQ16: test, power down, output enable controls
// RQ17: offset loop options, five bits
// RQ18: ten-bit fine offset across two registers
// RQ19: four-bit coarse offset, reset max negative
// RQ20: soft reset bit restores defaults
// RQ21: unused bits dropped, power down keeps contents
// RQ22: only full frames on strobe rise count
module ifsc_serial_config
    import ifsc_pkg::*;
#(
    parameter int ADDR_BITS  = `IFSC_ADDR_BITS,
    parameter int DATA_BITS  = `IFSC_DATA_BITS,
    parameter int FRAME_BITS = `IFSC_FRAME_BITS
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       sclk, // RQ1
    input  wire logic       load,
    input  wire logic       serial_in,
    output logic [7:0]      gain_code,
    output logic [5:0]      black_offset_target,
    output logic [2:0]      black_sample_delay,
    output logic [2:0]      video_sample_delay,
    output logic [1:0]      delay_test_bits,
    output logic            reset_noise_clocked,
    output logic            strobe_test_bit,
    output logic            clamp_with_cal,
    output logic            black_strobe_polarity,
    output logic            video_strobe_polarity,
    output logic            clamp_polarity,
    output logic            cal_polarity,
    output logic            delay_test_en,
    output logic            direct_converter_input,
    output logic            power_down_bit,
    output logic            digital_out_en,
    output logic            cal_hold,
    output logic            speed_up_en,
    output logic            noise_filter_on,
    output logic            noise_filter_narrow,
    output logic            manual_dac,
    output logic [9:0]      fine_offset_dac,
    output logic [3:0]      coarse_offset_dac,
    output logic            chip_reset,
    output logic            frame_discard
);

    // ---------------------------------------------------------------
    // elaboration checks
    // ---------------------------------------------------------------
    if (ADDR_BITS != `IFSC_ADDR_BITS || DATA_BITS != `IFSC_DATA_BITS ||
        FRAME_BITS != ADDR_BITS + DATA_BITS) begin : g_bad_cfg
        $error("frame layout must be 4 address bits and 8 data bits");
    end

    localparam ifsc_regs_s REGS_RESET = '{
        gain_code:           `IFSC_R_GAIN,
        black_offset_target: `IFSC_R_TARGET,
        aperture_delays:     `IFSC_R_DELAY,
        strobe_polarity_cfg: `IFSC_R_STROBE,
        power_output_ctrl:   `IFSC_R_CTRL,
        offset_loop_cfg:     `IFSC_R_LOOP,
        fine_offset_high:    `IFSC_R_FINE_HI,
        fine_offset_low:     `IFSC_R_FINE_LO,
        coarse_offset:       `IFSC_R_COARSE
    };

    // ---------------------------------------------------------------
    // shift clock side
    // ---------------------------------------------------------------
    ifsc_link_s lnk;
    ifsc_link_s next_lnk;
    logic       frame_start;

    // set by the strobe itself, since sclk is idle while it is high;
    // the first edge after the strobe falls starts a fresh count
    always_ff @(posedge sclk or posedge load) begin
        if (load) begin
            frame_start <= 1'b1;
        end else begin
            frame_start <= 1'b0;
        end
    end

    always_comb begin
        next_lnk = lnk;
        if (!load) begin // RQ4
            next_lnk.shift_word = {lnk.shift_word[10:0], serial_in}; // RQ2 RQ3
            if (frame_start) begin
                next_lnk.bit_cnt = 4'h1;
            end else if (lnk.bit_cnt != 4'hF) begin
                // saturates so an overlong frame never looks complete
                next_lnk.bit_cnt = lnk.bit_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge sclk) begin
        lnk <= next_lnk;
    end

    // ---------------------------------------------------------------
    // system clock side
    // ---------------------------------------------------------------
    ifsc_core_s st;
    ifsc_core_s next_st;
    logic [3:0] f_addr;
    logic [7:0] f_data;
    logic       load_rise;
    logic       frame_full;

    // the word is quasi-static here: no sclk edge after the strobe rose
    assign f_addr     = lnk.shift_word[11:8];
    assign f_data     = lnk.shift_word[7:0];
    assign load_rise  = st.load_s2 & ~st.load_s3;
    assign frame_full = (lnk.bit_cnt == `IFSC_CNT_FULL);

    always_comb begin
        next_st            = st;
        next_st.load_s1    = load;
        next_st.load_s2    = st.load_s1;
        next_st.load_s3    = st.load_s2;
        next_st.chip_reset = 1'b0;
        next_st.discard    = 1'b0;
        // power down does not touch contents; writes stay accepted
        if (load_rise && !frame_full) begin
            next_st.discard = 1'b1; // RQ22
        end else if (load_rise) begin // RQ5
            // any address is taken as is, unknown ones drop the byte
            case (f_addr) // RQ6
                `IFSC_A_GAIN: begin
                    next_st.regs.gain_code = f_data & `IFSC_M_GAIN; // RQ11
                end
                `IFSC_A_TARGET: begin
                    next_st.regs.black_offset_target =
                        f_data & `IFSC_M_TARGET; // RQ12 RQ21
                end
                `IFSC_A_DELAY: begin
                    next_st.regs.aperture_delays = f_data & `IFSC_M_DELAY; // RQ13
                end
                `IFSC_A_STROBE: begin
                    next_st.regs.strobe_polarity_cfg =
                        f_data & `IFSC_M_STROBE; // RQ14 RQ15
                end
                `IFSC_A_CTRL: begin
                    next_st.regs.power_output_ctrl = f_data & `IFSC_M_CTRL; // RQ16
                end
                `IFSC_A_LOOP: begin
                    next_st.regs.offset_loop_cfg = f_data & `IFSC_M_LOOP; // RQ17
                end
                `IFSC_A_FINE_HI: begin
                    next_st.regs.fine_offset_high =
                        f_data & `IFSC_M_FINE_HI; // RQ18
                end
                `IFSC_A_FINE_LO: begin
                    next_st.regs.fine_offset_low =
                        f_data & `IFSC_M_FINE_LO; // RQ18 RQ21
                end
                `IFSC_A_COARSE: begin
                    next_st.regs.coarse_offset = f_data & `IFSC_M_COARSE; // RQ19
                end
                `IFSC_A_SOFT_RST: begin
                    if (f_data[`IFSC_B_SOFT_RST]) begin
                        next_st.regs       = REGS_RESET; // RQ20
                        next_st.chip_reset = 1'b1;
                    end
                end
                default: begin
                    next_st.discard = 1'b1; // RQ7
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st.load_s1    <= 1'b1;
            st.load_s2    <= 1'b1;
            st.load_s3    <= 1'b1;
            st.regs       <= REGS_RESET;
            st.chip_reset <= 1'b0;
            st.discard    <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------
    // decoded fields straight from the bank flops; chip_reset and frame_discard from their pulse flops
    // ---------------------------------------------------------------
    assign gain_code              = st.regs.gain_code;
    assign black_offset_target    = st.regs.black_offset_target[5:0];
    assign black_sample_delay     = st.regs.aperture_delays[7:5];
    assign video_sample_delay     = st.regs.aperture_delays[4:2];
    assign delay_test_bits        = st.regs.aperture_delays[1:0];
    assign reset_noise_clocked    = st.regs.strobe_polarity_cfg[`IFSC_B_RSTREJ];
    assign strobe_test_bit        = st.regs.strobe_polarity_cfg[`IFSC_B_STR_TEST];
    assign clamp_with_cal         = st.regs.strobe_polarity_cfg[`IFSC_B_CLAMP_OPT];
    assign black_strobe_polarity  = st.regs.strobe_polarity_cfg[`IFSC_B_BLK_POL];
    assign video_strobe_polarity  = st.regs.strobe_polarity_cfg[`IFSC_B_VID_POL];
    assign clamp_polarity         = st.regs.strobe_polarity_cfg[`IFSC_B_CLAMP_POL];
    assign cal_polarity           = st.regs.strobe_polarity_cfg[`IFSC_B_CAL_POL];
    assign delay_test_en          = st.regs.power_output_ctrl[`IFSC_B_DLY_TEST];
    assign direct_converter_input = st.regs.power_output_ctrl[`IFSC_B_ADC_TEST];
    assign power_down_bit         = st.regs.power_output_ctrl[`IFSC_B_PWR_DOWN];
    assign digital_out_en         = st.regs.power_output_ctrl[`IFSC_B_OUT_EN];
    assign cal_hold               = st.regs.offset_loop_cfg[`IFSC_B_CAL_HOLD];
    assign speed_up_en            = st.regs.offset_loop_cfg[`IFSC_B_SPEED_UP];
    assign noise_filter_on        = st.regs.offset_loop_cfg[`IFSC_B_NF_ON];
    assign noise_filter_narrow    = st.regs.offset_loop_cfg[`IFSC_B_NF_NARROW];
    assign manual_dac             = st.regs.offset_loop_cfg[`IFSC_B_MAN_DAC];
    assign fine_offset_dac        = {st.regs.fine_offset_high,
                                     st.regs.fine_offset_low[1:0]};
    assign coarse_offset_dac      = st.regs.coarse_offset[3:0];
    assign chip_reset             = st.chip_reset;
    assign frame_discard          = st.discard;

endmodule

// ### testbench/ifsc_host_model.sv
// host side of the three-wire port: strobe, shift clock, serial data
// assumes one caller of send() at a time
`timescale 1ns/1ps
module ifsc_host_model (
    output logic sclk,
    output logic load,
    output logic serial_in
);
    initial begin
        sclk      = 1'b0;
        load      = 1'b1;
        serial_in = 1'b0;
    end

    // nbits other than 12 makes a broken frame on purpose
    task automatic send(input logic [11:0] word, input int nbits);
        load = 1'b0;
        #15;
        for (int i = 0; i < nbits; i++) begin
            serial_in = word[11 - (i % 12)];
            #15 sclk = 1'b1;
            #15 sclk = 1'b0;
        end
        // released line must not show the stale bit
        serial_in = ~serial_in;
        #15 load = 1'b1;
        // frames only on request, so the line stays quiet during video
        #90;
    endtask
endmodule

// ### testbench/ifsc_serial_config_checker.sv
// timing and default-value checks on six of the bank outputs of the configuration port
// assumes binding to ifsc_serial_config; load is seen raw on mclk
`timescale 1ns/1ps
module ifsc_serial_config_checker
    import ifsc_pkg::*;
(
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       load,
    input wire logic [7:0] gain_code,
    input wire logic [5:0] black_offset_target,
    input wire logic       clamp_with_cal,
    input wire logic       digital_out_en,
    input wire logic [9:0] fine_offset_dac,
    input wire logic [3:0] coarse_offset_dac,
    input wire logic       chip_reset,
    input wire logic       frame_discard
);
    logic        ld_q;
    logic [3:0]  since_rise;
    logic [29:0] watched;
    assign watched = {gain_code, black_offset_target, clamp_with_cal, digital_out_en,
                      fine_offset_dac, coarse_offset_dac};

    // saturates so a stale rise never excuses a late change
    always_ff @(posedge mclk) begin
        if (rst) begin
            ld_q       <= 1'b1;
            since_rise <= 4'hF;
        end else begin
            ld_q <= load;
            if (load && !ld_q)
                since_rise <= 4'h0;
            else if (since_rise != 4'hF)
                since_rise <= since_rise + 4'h1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_recent_rise;
        since_rise inside {[1:6]};
    endsequence
    sequence s_quiet_low;
        (!load) [*6];
    endsequence

    a_change_after_rise: assert property ($changed(watched) |-> s_recent_rise)
        else $error("bank changed without a strobe rise");
    a_soft_reset_when: assert property (chip_reset |-> s_recent_rise)
        else $error("soft reset pulse without a strobe rise");
    a_discard_when: assert property (frame_discard |-> s_recent_rise)
        else $error("discard pulse without a strobe rise");
    a_soft_reset_vals: assert property (chip_reset |-> watched == 30'h0020_C000)
        else $error("soft reset left a field off its default");
    a_discard_keeps: assert property (frame_discard |-> $stable(watched))
        else $error("discarded frame changed the bank");
    a_quiet_hold: assert property (s_quiet_low |-> $stable(watched))
        else $error("bank changed while shifting");
    a_pulse_single: assert property ((chip_reset || frame_discard) |=>
        !(chip_reset || frame_discard)) else $error("commit pulse longer than one cycle");
    a_reset_values: assert property ($fell(rst) |-> watched == 30'h0020_C000)
        else $error("field off its default after reset");
endmodule

bind ifsc_serial_config ifsc_serial_config_checker ifsc_serial_config_checker_inst (
    .mclk, .rst, .load, .gain_code, .black_offset_target, .clamp_with_cal,
    .digital_out_en, .fine_offset_dac, .coarse_offset_dac, .chip_reset, .frame_discard);

// ### testbench/test_imager_frontend_serial_config.sv
// self-checking bench of the serial configuration port
// assumes the host model drives the link and the checker is bound
`timescale 1ns/1ps
module test_imager_frontend_serial_config
    import ifsc_pkg::*;
;
    localparam logic [7:0] DEFAULTS [0:8] = '{8'h00, 8'h20, 8'h00, 8'h10, 8'h01,
                                              8'h0C, 8'h00, 8'h00, 8'h00};
    logic        mclk;
    logic        rst;
    logic        sclk;
    logic        load;
    logic        serial_in;
    wire  [51:0] obs;
    logic        chip_reset;
    logic        frame_discard;
    logic [7:0]  bank [0:8];
    int          n_fail;
    int          n_compared;
    int          n_disc;
    int          n_srst;
    int          cycles;

    ifsc_host_model ifsc_host_model_inst (.sclk, .load, .serial_in);
    ifsc_serial_config ifsc_serial_config_inst (
        .mclk, .rst, .sclk, .load, .serial_in,
        .gain_code(obs[51:44]), .black_offset_target(obs[43:38]),
        .black_sample_delay(obs[37:35]), .video_sample_delay(obs[34:32]),
        .delay_test_bits(obs[31:30]), .reset_noise_clocked(obs[29]),
        .strobe_test_bit(obs[28]), .clamp_with_cal(obs[27]),
        .black_strobe_polarity(obs[26]), .video_strobe_polarity(obs[25]),
        .clamp_polarity(obs[24]), .cal_polarity(obs[23]), .delay_test_en(obs[22]),
        .direct_converter_input(obs[21]), .power_down_bit(obs[20]),
        .digital_out_en(obs[19]), .cal_hold(obs[18]), .speed_up_en(obs[17]),
        .noise_filter_on(obs[16]), .noise_filter_narrow(obs[15]), .manual_dac(obs[14]),
        .fine_offset_dac(obs[13:4]), .coarse_offset_dac(obs[3:0]),
        .chip_reset, .frame_discard);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // slicing drops the unused bits of each byte
    function automatic logic [51:0] expect_of();
        return {bank[0], bank[1][5:0], bank[2], bank[3][6:0], bank[4][3:0],
                bank[5][4:0], bank[6], bank[7][1:0], bank[8][3:0]};
    endfunction

    task automatic check(input string what, input logic [51:0] exp, input logic [51:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d, input int n);
        @(posedge mclk);
        #1;
        ifsc_host_model_inst.send({a, d}, n);
        if (n == 12 && a <= 4'h8)
            bank[a] = d;
        if (n == 12 && a == 4'hF && d[0])
            bank = DEFAULTS;
        check("bank", expect_of(), obs);
    endtask

    task automatic test_done();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------
    // clock, pulse counting, hang guard
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // sampled mid-cycle so pulses are settled
    always @(negedge mclk) begin
        cycles++;
        if (frame_discard === 1'b1)
            n_disc++;
        if (chip_reset === 1'b1)
            n_srst++;
        if (cycles == 5000) begin
            n_fail++;
            test_done();
        end
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        rst  = 1'b1;
        bank = DEFAULTS;
        repeat (4) @(posedge mclk);
        #1 rst = 1'b0;
        check("reset", expect_of(), obs);
        wr(4'hF, 8'h01, 12);
        wr(4'h0, 8'hA6, 12);
        wr(4'h1, 8'hFF, 12);
        wr(4'h2, 8'hB4, 12);
        wr(4'h3, 8'hCB, 12);
        wr(4'h4, 8'hFA, 12);
        wr(4'h5, 8'hF5, 12);
        wr(4'h6, 8'h9C, 12);
        wr(4'h7, 8'hFE, 12);
        wr(4'h8, 8'hFB, 12);
        for (int a = 9; a < 15; a++)
            wr(4'(a), 8'hFF, 12);
        wr(4'h0, 8'h11, 11);
        wr(4'h0, 8'h11, 13);
        wr(4'hF, 8'hFE, 12);
        wr(4'hF, 8'h01, 12);
        check("discards", 52'(8), 52'(n_disc));
        check("soft resets", 52'(2), 52'(n_srst));
        test_done();
    end
endmodule
